// ---- hdl/sies_irq_enable.v ----
// Interrupt enable, flag and request logic of the clock and supply controller
`timescale 1ns/1ns
`include "sies_regs.vh"

module sies_irq_enable (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Status sources, asynchronous to sys_clk
  input  wire        pll_lock_fall,
  input  wire        pll_lock_rise,
  input  wire        brownout_sync_ready,
  input  wire        brownout_detected,
  input  wire        brownout_ready,
  input  wire        fll_ref_clock_stopped,
  input  wire        fll_lock_coarse,
  input  wire        fll_lock_fine,
  input  wire        fll_out_of_bounds,
  input  wire        fll_ready,
  // Interrupt request
  output reg         irq
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam [31:0] IMPL_MASK  = `SIES_IMPL_MASK;
  localparam [31:0] RST_ENABLE = `SIES_RST_ENABLE;
  localparam [31:0] RST_FLAG   = `SIES_RST_FLAG;
  localparam [31:0] ZERO_WORD  = 32'h00000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam integer P_PLL_FALL   = `SIES_POS_PLL_LOCK_FALL;
  localparam integer P_PLL_RISE   = `SIES_POS_PLL_LOCK_RISE;
  localparam integer P_BOD_SYNC   = `SIES_POS_BOD_SYNC_READY;
  localparam integer P_BOD_DET    = `SIES_POS_BOD_DETECTED;
  localparam integer P_BOD_READY  = `SIES_POS_BOD_READY;
  localparam integer P_FLL_STOP   = `SIES_POS_FLL_REF_STOP;
  localparam integer P_FLL_COARSE = `SIES_POS_FLL_COARSE;
  localparam integer P_FLL_FINE   = `SIES_POS_FLL_FINE;
  localparam integer P_FLL_OOB    = `SIES_POS_FLL_OOB;
  localparam integer P_FLL_READY  = `SIES_POS_FLL_READY;

  // ----------------------------------------------------------------
  // Register select codes
  // ----------------------------------------------------------------
  localparam [2:0] SEL_NONE   = 3'h0;
  localparam [2:0] SEL_CLEAR  = 3'h1;
  localparam [2:0] SEL_SET    = 3'h2;
  localparam [2:0] SEL_FLAG   = 3'h3;
  localparam [2:0] SEL_STATUS = 3'h4;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Unmapped offsets select nothing: writes vanish and reads give zero
  function [2:0] reg_select;
    input [7:0] addr;
    begin
      if (addr == `SIES_OFF_ENCLR) begin
        reg_select = SEL_CLEAR;
      end else if (addr == `SIES_OFF_ENSET) begin
        reg_select = SEL_SET;
      end else if (addr == `SIES_OFF_FLAG) begin
        reg_select = SEL_FLAG;
      end else if (addr == `SIES_OFF_STAT) begin
        reg_select = SEL_STATUS;
      end else begin
        reg_select = SEL_NONE;
      end
    end
  endfunction

  wire [2:0]  sel_addr;
  wire [31:0] wdata_impl;
  reg         wr_clr;
  reg         wr_set;
  reg         wr_flag;
  reg         rd_enable;
  reg         rd_flag;
  reg         rd_status;

  assign sel_addr   = reg_select(reg_addr);
  assign wdata_impl = reg_wdata & IMPL_MASK;

  // Write strobes
  always @* begin
    wr_clr  = 1'b0;
    wr_set  = 1'b0;
    wr_flag = 1'b0;
    if (reg_wr) begin
      if (sel_addr == SEL_CLEAR) begin
        wr_clr = 1'b1;
      end else if (sel_addr == SEL_SET) begin
        wr_set = 1'b1;
      end else if (sel_addr == SEL_FLAG) begin
        wr_flag = 1'b1;
      end
    end
  end

  // Read selects; both enable offsets show the same mask
  always @* begin
    rd_enable = 1'b0;
    rd_flag   = 1'b0;
    rd_status = 1'b0;
    if (reg_rd) begin
      if (sel_addr == SEL_CLEAR) begin
        rd_enable = 1'b1;
      end else if (sel_addr == SEL_SET) begin
        rd_enable = 1'b1;
      end else if (sel_addr == SEL_FLAG) begin
        rd_flag = 1'b1;
      end else if (sel_addr == SEL_STATUS) begin
        rd_status = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Source gathering
  // ----------------------------------------------------------------
  reg  [31:0] src_raw;

  always @* begin
    src_raw               = ZERO_WORD;
    src_raw[P_PLL_FALL]   = pll_lock_fall;
    src_raw[P_PLL_RISE]   = pll_lock_rise;
    src_raw[P_BOD_SYNC]   = brownout_sync_ready;
    src_raw[P_BOD_DET]    = brownout_detected;
    src_raw[P_BOD_READY]  = brownout_ready;
    src_raw[P_FLL_STOP]   = fll_ref_clock_stopped;
    src_raw[P_FLL_COARSE] = fll_lock_coarse;
    src_raw[P_FLL_FINE]   = fll_lock_fine;
    src_raw[P_FLL_OOB]    = fll_out_of_bounds;
    src_raw[P_FLL_READY]  = fll_ready;
  end

  // ----------------------------------------------------------------
  // Per implemented position: synchroniser, edge detector, enable and flag
  // ----------------------------------------------------------------
  wire [31:0] sync2_w;
  wire [31:0] enable_d;
  wire [31:0] enable_w;
  wire [31:0] flag_d;
  wire [31:0] flag_w;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_pos
      if (IMPL_MASK[gi]) begin : g_impl
        reg  sync1_q;
        reg  sync2_q;
        reg  prev_q;
        reg  enable_q;
        reg  enable_n;
        reg  flag_q;
        reg  flag_n;
        wire rise;
        wire set_hit;
        wire clr_hit;
        wire flag_clr;

        // First stage may go metastable; only the second stage reads it
        always @(posedge sys_clk) begin
          if (rst) begin
            sync1_q <= 1'b0;
          end else begin
            sync1_q <= src_raw[gi];
          end
        end

        always @(posedge sys_clk) begin
          if (rst) begin
            sync2_q <= 1'b0;
          end else begin
            sync2_q <= sync1_q;
          end
        end

        // Edge history starts at the idle level, so reset makes no false edge
        always @(posedge sys_clk) begin
          if (rst) begin
            prev_q <= 1'b0;
          end else begin
            prev_q <= sync2_q;
          end
        end

        assign rise     = sync2_q & ~prev_q;
        assign set_hit  = wr_set & wdata_impl[gi];
        assign clr_hit  = wr_clr & wdata_impl[gi];
        assign flag_clr = wr_flag & wdata_impl[gi];

        // Zero bits of a set or clear write leave the enable alone
        always @* begin
          enable_n = enable_q;
          if (set_hit) begin
            enable_n = 1'b1;
          end else if (clr_hit) begin
            enable_n = 1'b0;
          end
        end

        // A new edge in the cycle of a write-one clear keeps the flag set
        always @* begin
          flag_n = flag_q;
          if (rise) begin
            flag_n = 1'b1;
          end else if (flag_clr) begin
            flag_n = 1'b0;
          end
        end

        always @(posedge sys_clk) begin
          if (rst) begin
            enable_q <= RST_ENABLE[gi];
          end else begin
            enable_q <= enable_n;
          end
        end

        always @(posedge sys_clk) begin
          if (rst) begin
            flag_q <= RST_FLAG[gi];
          end else begin
            flag_q <= flag_n;
          end
        end

        assign sync2_w[gi]  = sync2_q;
        assign enable_d[gi] = enable_n;
        assign enable_w[gi] = enable_q;
        assign flag_d[gi]   = flag_n;
        assign flag_w[gi]   = flag_q;
      end else begin : g_none
        // Reserved positions hold no storage and read as zero
        assign sync2_w[gi]  = 1'b0;
        assign enable_d[gi] = 1'b0;
        assign enable_w[gi] = 1'b0;
        assign flag_d[gi]   = 1'b0;
        assign flag_w[gi]   = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Request taps
  // ----------------------------------------------------------------
  // Next values, so irq moves on the same edge as its flag and enable
  wire        en_pll_fall    = enable_d[P_PLL_FALL];
  wire        fl_pll_fall    = flag_d[P_PLL_FALL];
  wire        req_pll_fall   = en_pll_fall & fl_pll_fall;

  wire        en_pll_rise    = enable_d[P_PLL_RISE];
  wire        fl_pll_rise    = flag_d[P_PLL_RISE];
  wire        req_pll_rise   = en_pll_rise & fl_pll_rise;

  wire        en_bod_sync    = enable_d[P_BOD_SYNC];
  wire        fl_bod_sync    = flag_d[P_BOD_SYNC];
  wire        req_bod_sync   = en_bod_sync & fl_bod_sync;

  wire        en_bod_det     = enable_d[P_BOD_DET];
  wire        fl_bod_det     = flag_d[P_BOD_DET];
  wire        req_bod_det    = en_bod_det & fl_bod_det;

  wire        en_bod_ready   = enable_d[P_BOD_READY];
  wire        fl_bod_ready   = flag_d[P_BOD_READY];
  wire        req_bod_ready  = en_bod_ready & fl_bod_ready;

  wire        en_fll_stop    = enable_d[P_FLL_STOP];
  wire        fl_fll_stop    = flag_d[P_FLL_STOP];
  wire        req_fll_stop   = en_fll_stop & fl_fll_stop;

  wire        en_fll_coarse  = enable_d[P_FLL_COARSE];
  wire        fl_fll_coarse  = flag_d[P_FLL_COARSE];
  wire        req_fll_coarse = en_fll_coarse & fl_fll_coarse;

  wire        en_fll_fine    = enable_d[P_FLL_FINE];
  wire        fl_fll_fine    = flag_d[P_FLL_FINE];
  wire        req_fll_fine   = en_fll_fine & fl_fll_fine;

  wire        en_fll_oob     = enable_d[P_FLL_OOB];
  wire        fl_fll_oob     = flag_d[P_FLL_OOB];
  wire        req_fll_oob    = en_fll_oob & fl_fll_oob;

  wire        en_fll_ready   = enable_d[P_FLL_READY];
  wire        fl_fll_ready   = flag_d[P_FLL_READY];
  wire        req_fll_ready  = en_fll_ready & fl_fll_ready;

  wire        irq_pll        = req_pll_fall | req_pll_rise;
  wire        irq_bod        = req_bod_sync | req_bod_det | req_bod_ready;
  wire        irq_fll        = req_fll_stop |
                               req_fll_coarse |
                               req_fll_fine |
                               req_fll_oob |
                               req_fll_ready;
  wire        irq_d          = irq_pll | irq_bod | irq_fll;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  reg  [31:0] rdata_d;

  always @* begin
    rdata_d = ZERO_WORD;
    if (rd_enable) begin
      rdata_d = enable_w;
    end else if (rd_flag) begin
      rdata_d = flag_w;
    end else if (rd_status) begin
      rdata_d = sync2_w;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Read data stand only in the cycle after the strobe, zero otherwise
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= ZERO_WORD;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

endmodule

// ---- hdl/sies_regs.vh ----
// Register map and constants of the interrupt enable block
`ifndef SIES_REGS_VH
`define SIES_REGS_VH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define SIES_OFF_ENCLR  8'h00
`define SIES_OFF_ENSET  8'h04
`define SIES_OFF_FLAG   8'h08
`define SIES_OFF_STAT   8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SIES_POS_FLL_READY       4
`define SIES_POS_FLL_OOB         5
`define SIES_POS_FLL_FINE        6
`define SIES_POS_FLL_COARSE      7
`define SIES_POS_FLL_REF_STOP    8
`define SIES_POS_BOD_READY       9
`define SIES_POS_BOD_DETECTED    10
`define SIES_POS_BOD_SYNC_READY  11
`define SIES_POS_PLL_LOCK_RISE   15
`define SIES_POS_PLL_LOCK_FALL   16

// ----------------------------------------------------------------
// Implemented positions and reset values
// ----------------------------------------------------------------
`define SIES_IMPL_MASK   32'h00018ff0
`define SIES_RST_ENABLE  32'h00000000
`define SIES_RST_FLAG    32'h00000000

`endif

// ---- tb/sies_irq_enable_assertions.sv ----
// Port checker of the interrupt enable block
`timescale 1ns/1ns
`include "sies_regs.vh"
module sies_chk (
  input logic        sys_clk,rst,reg_wr,reg_rd,irq,
  input logic [7:0]  reg_addr,
  input logic [31:0] reg_wdata,reg_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata==0) else $error("rdata");
  a_unused_zero: assert property ((reg_rdata&~`SIES_IMPL_MASK)==0) else $error("unused");
  a_irq_reset: assert property ($past(rst) |-> !irq) else $error("irq rst");
  a_read_alias: assert property (reg_rd&&reg_addr==8'h04 ##1 reg_rd&&reg_addr==8'h00
    |=> reg_rdata==$past(reg_rdata)) else $error("alias");
  a_set_sticks: assert property (reg_wr&&reg_addr==8'h04 ##1 reg_rd&&reg_addr==8'h04
    |=> (reg_rdata&$past(reg_wdata,2))==($past(reg_wdata,2)&`SIES_IMPL_MASK)) else $error("set");
  a_zero_keeps: assert property (reg_rd&&reg_addr==8'h00 ##1 reg_wr&&reg_addr==8'h04
    &&reg_wdata==0 ##1 reg_rd&&reg_addr==8'h04 |=> reg_rdata==$past(reg_rdata,2)) else $error("zero");
  a_clear_drops: assert property (reg_wr&&reg_addr==8'h00 ##1 reg_rd&&reg_addr==8'h04
    |=> (reg_rdata&$past(reg_wdata,2))==0) else $error("clear");
  a_irq_off: assert property (reg_wr&&reg_addr==8'h00&&reg_wdata==32'hffffffff |=> !irq)
    else $error("irq off");
endmodule
bind sies_irq_enable sies_chk chk_u (.sys_clk,.rst,.reg_wr,.reg_rd,.irq,.reg_addr,.reg_wdata,
  .reg_rdata);

// ---- tb/tb_sies_irq_enable.sv ----
// Bench of the interrupt enable block
`timescale 1ns/1ns
`include "sies_regs.vh"
module tb_sies_irq_enable;
  logic        sys_clk=0,rst=1,reg_wr=0,reg_rd=0;
  logic [7:0]  reg_addr=0;
  logic [31:0] reg_wdata=0,m=0,b;
  logic [16:0] src=0;
  wire  [31:0] reg_rdata;
  wire         irq;
  int          num_errors=0,n_tests=0,cyc=0;
  sies_irq_enable dut_u (.sys_clk,.rst,.reg_addr,.reg_wdata,.reg_wr,.reg_rd,.reg_rdata,.irq,
    .pll_lock_fall(src[16]),.pll_lock_rise(src[15]),.brownout_sync_ready(src[11]),
    .brownout_detected(src[10]),.brownout_ready(src[9]),.fll_ref_clock_stopped(src[8]),
    .fll_lock_coarse(src[7]),.fll_lock_fine(src[6]),.fll_out_of_bounds(src[5]),.fll_ready(src[4]));
  initial forever #4 sys_clk=~sys_clk;
  // A hang ends in the report; all tests need under 400 cycles
  always @(posedge sys_clk) if (++cyc==1000) begin
    num_errors++;
    close_out;
  end
  // One bus cycle per call, so strobes can run back to back
  task bus(input logic w,r,input logic [7:0] a,input logic [31:0] d);
    @(posedge sys_clk);
    {reg_wr,reg_rd,reg_addr,reg_wdata}<={w,r,a,d};
  endtask
  task chk(input string n,input logic [31:0] e,g);
    n_tests++;
    if (g!==e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h",n,e,g);
    end
  endtask
  task close_out;
    $display("Checks %0d errors %0d",n_tests,num_errors);
    if (num_errors==0&&n_tests>0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task t_reset;
    bus(0,1,8'h04,0);
    bus(0,1,8'h08,0);
    #1 chk("enable",0,reg_rdata);
    bus(0,1,8'h10,0);
    #1 chk("flags",0,reg_rdata);
    bus(0,0,8'h00,0);
    #1 chk("unmapped",0,reg_rdata);
  endtask
  // Every bit position, reserved ones too, then zero writes in between
  task t_mask;
    for (int p=0;p<32;p++) begin
      b=32'h1<<p;
      m=m|(b&`SIES_IMPL_MASK);
      bus(1,0,8'h04,b);
      bus(0,1,8'h04,0);
      bus(0,1,8'h00,0);
      #1 chk("set",m,reg_rdata);
      bus(1,0,8'h04,0);
      bus(0,1,8'h04,0);
      bus(0,0,8'h00,0);
      #1 chk("zero keeps",m,reg_rdata);
    end
    bus(1,0,8'h00,32'h8000);
    bus(0,1,8'h04,0);
    bus(1,0,8'h00,32'hffffffff);
    #1 chk("clear",m&~32'h8000,reg_rdata);
  endtask
  task t_irq;
    for (int p=4;p<17;p++) begin
      b=32'h1<<p;
      if ((b&`SIES_IMPL_MASK)!=0) begin
        bus(0,0,8'h00,0);
        src<=b[16:0];
        repeat (4) bus(0,0,8'h00,0);
        #1 chk("masked",0,irq);
        bus(0,1,8'h0c,0);
        bus(0,1,8'h08,0);
        #1 chk("status",b,reg_rdata);
        bus(1,0,8'h04,b);
        #1 chk("flag",b,reg_rdata);
        bus(1,0,8'h08,b);
        #1 chk("irq",1,irq);
        bus(1,0,8'h00,b);
        src<=0;
        #1 chk("flag clear",0,irq);
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst<=0;
    t_reset;
    t_mask;
    t_irq;
    close_out;
  end
endmodule
